// *** inc/uart_cmd_pkg.sv ***
// constants and types shared by the uart command register logic
package uart_cmd_pkg;
    // ---------------------------------------------------------------
    // register map (byte addresses on the wishbone bus)
    // ---------------------------------------------------------------
    localparam int unsigned ADR_W = 4;
    localparam int unsigned DAT_W = 32;
    localparam int unsigned SEL_W = 4;
    localparam logic [ADR_W-1:0] OFS_COMMAND = 4'h0;
    localparam logic [ADR_W-1:0] OFS_STATUS = 4'h4;
    // ---------------------------------------------------------------
    // command word fields
    // ---------------------------------------------------------------
    localparam int unsigned CMD_AUTOBAUD_BIT = 7;
    localparam int unsigned CMD_SEL_HI = 6;
    localparam int unsigned CMD_SEL_LO = 4;
    typedef enum logic [2:0] {
        SEL_NONE = 3'h0,
        SEL_MODE_PTR = 3'h1,
        SEL_RX_RESET = 3'h2,
        SEL_TX_RESET = 3'h3,
        SEL_ERR_CLEAR = 3'h4,
        SEL_DBRK_CLEAR = 3'h5,
        SEL_BRK_START = 3'h6,
        SEL_BRK_STOP = 3'h7
    } misc_sel_e;
    // ---------------------------------------------------------------
    // status word fields and reset values
    // ---------------------------------------------------------------
    localparam int unsigned ST_AB_ENABLE = 0;
    localparam int unsigned ST_AB_COMPLETE = 1;
    localparam int unsigned ST_BRK_WAIT = 2;
    localparam int unsigned ST_BRK_ON = 3;
    localparam logic RST_AB_ENABLE = 1'b0;
    localparam logic RST_AB_COMPLETE = 1'b0;
    localparam int unsigned PULSE_W = 7;
    // break sequencer states
    typedef enum logic [1:0] {
        BRK_IDLE = 2'b00,
        BRK_WAIT = 2'b01,
        BRK_ON = 2'b10
    } brk_state_e;
endpackage : uart_cmd_pkg

// *** inc/uart_cmd_if.sv ***
// command strobe and decoded action pulses between register file and decoder
`timescale 1ns/1ps
interface uart_cmd_if;
    logic wr_stb;
    logic [7:0] wr_data;
    logic mode_ptr_reset;
    logic rx_reset;
    logic tx_reset;
    logic err_clear;
    logic dbrk_clear;
    logic brk_start;
    logic brk_stop;
    modport decoder (
        input wr_stb, wr_data,
        output mode_ptr_reset, rx_reset, tx_reset, err_clear, dbrk_clear,
        output brk_start, brk_stop
    );
    modport owner (
        output wr_stb, wr_data,
        input mode_ptr_reset, rx_reset, tx_reset, err_clear, dbrk_clear,
        input brk_start, brk_stop
    );
endinterface : uart_cmd_if

// *** hw/uart_cmd_decode.sv ***
// decoder of the single-command selector into one-cycle action pulses
`timescale 1ns/1ps
module uart_cmd_decode (
    input wire logic i_clock,
    input wire logic i_nrst,
    uart_cmd_if.decoder cmd
);
    import uart_cmd_pkg::*;

    logic [PULSE_W-1:0] pulse_ff;
    logic [PULSE_W-1:0] nxt_pulse;
    misc_sel_e sel;

    // ---------------------------------------------------------------
    // selector decode
    // ---------------------------------------------------------------
    assign sel = misc_sel_e'(cmd.wr_data[CMD_SEL_HI:CMD_SEL_LO]);

    // at most one pulse per write, none when idle
    always_comb begin
        nxt_pulse = '0; // R16
        if (cmd.wr_stb) begin
            unique case (sel)
                SEL_NONE: nxt_pulse = '0; // R6
                SEL_MODE_PTR: nxt_pulse[0] = 1'b1; // R7
                SEL_RX_RESET: nxt_pulse[1] = 1'b1; // R8
                SEL_TX_RESET: nxt_pulse[2] = 1'b1; // R10
                SEL_ERR_CLEAR: nxt_pulse[3] = 1'b1; // R12
                SEL_DBRK_CLEAR: nxt_pulse[4] = 1'b1; // R13
                SEL_BRK_START: nxt_pulse[5] = 1'b1; // R14
                SEL_BRK_STOP: nxt_pulse[6] = 1'b1; // R15
            endcase
        end
    end

    // pulse register
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            pulse_ff <= '0;
        end else begin
            pulse_ff <= nxt_pulse;
        end
    end

    assign cmd.mode_ptr_reset = pulse_ff[0];
    assign cmd.rx_reset = pulse_ff[1];
    assign cmd.tx_reset = pulse_ff[2];
    assign cmd.err_clear = pulse_ff[3];
    assign cmd.dbrk_clear = pulse_ff[4];
    assign cmd.brk_start = pulse_ff[5];
    assign cmd.brk_stop = pulse_ff[6];

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_nrst);

    a_none_no_pulse: assert property (cmd.wr_stb && sel == SEL_NONE |=> pulse_ff == '0) // R6
        else $error("selector zero produced an action");
    a_one_action: assert property ($onehot0(pulse_ff)) // R6
        else $error("more than one action at once");
    a_mode_ptr_pulse: assert property (cmd.wr_stb && sel == SEL_MODE_PTR |=> cmd.mode_ptr_reset) // R7
        else $error("mode pointer reset missing");
    a_rx_reset_pulse: assert property (cmd.wr_stb && sel == SEL_RX_RESET |=> cmd.rx_reset) // R8
        else $error("receiver reset missing");
    a_tx_reset_pulse: assert property (cmd.wr_stb && sel == SEL_TX_RESET |=> cmd.tx_reset) // R10
        else $error("transmitter reset missing");
    a_err_clear_pulse: assert property (cmd.wr_stb && sel == SEL_ERR_CLEAR |=> cmd.err_clear) // R12
        else $error("error clear missing");
    a_dbrk_clear_pulse: assert property (cmd.wr_stb && sel == SEL_DBRK_CLEAR |=> cmd.dbrk_clear) // R13
        else $error("delta break clear missing");
    a_pulse_single: assert property (pulse_ff != '0 |-> $past(cmd.wr_stb)) // R16
        else $error("action without a write");
endmodule : uart_cmd_decode

// *** hw/uart_command_decoder.sv ***
// uart command register: wishbone slave, autobaud control and break sequencer
// Functional notes
// [R1] software combines only non-conflicting commands per write
// [R2] command bit 7 enables automatic baud detection
// [R3] software clears then sets enable to recompute
// [R4] set autobaud complete once divider is loaded
// [R5] software zeroes both divider bytes before enabling
// [R6] bits 6..4 pick one action; zero does nothing
// [R7] selector 001 resets mode register pointer
// [R8] selector 010 resets receiver, flags and fifo pointer
// [R9] software prefers receiver reset over plain disable
// [R10] selector 011 resets transmitter and its flags
// [R11] software prefers transmitter reset over plain disable
// [R12] selector 100 clears break, framing, parity, overrun errors
// [R13] selector 101 clears the delta break flag
// [R14] selector 110 starts break after shifting character
// [R15] selector 111 ends break, resumes buffered characters
// [R16] each action is one pulse per write
//
// The Wishbone interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
module uart_command_decoder (
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [uart_cmd_pkg::ADR_W-1:0] i_wb_adr,
    input wire logic [uart_cmd_pkg::SEL_W-1:0] i_wb_sel,
    input wire logic [uart_cmd_pkg::DAT_W-1:0] i_wb_dat,
    output logic [uart_cmd_pkg::DAT_W-1:0] o_wb_dat,
    output logic o_wb_ack,
    input wire logic i_tx_enabled,
    input wire logic i_tx_shift_busy,
    input wire logic i_autobaud_loaded,
    output logic o_autobaud_enable,
    output logic o_mode_ptr_reset,
    output logic o_rx_reset,
    output logic o_tx_reset,
    output logic o_err_clear,
    output logic o_dbrk_clear,
    output logic o_tx_break,
    output logic o_tx_hold
);
    import uart_cmd_pkg::*;

    uart_cmd_if cmd ();

    // ---------------------------------------------------------------
    // wishbone slave
    // ---------------------------------------------------------------
    logic ack_ff;
    logic nxt_ack;
    logic [DAT_W-1:0] rdat_ff;
    logic [DAT_W-1:0] nxt_rdat;
    logic [DAT_W-1:0] status;
    logic wr_go;
    logic wr_cmd;
    logic wr_status;

    // a write takes effect at the edge where the master sees ack
    assign wr_go = i_wb_cyc && i_wb_stb && i_wb_we && ack_ff;
    assign wr_cmd = wr_go && i_wb_adr == OFS_COMMAND && i_wb_sel[0];
    assign wr_status = wr_go && i_wb_adr == OFS_STATUS && i_wb_sel[0];

    // ack one cycle after the request, dropped the cycle after
    always_comb begin
        nxt_ack = i_wb_cyc && i_wb_stb && !ack_ff;
        nxt_rdat = '0;
        if (nxt_ack && !i_wb_we && i_wb_adr == OFS_STATUS) begin
            nxt_rdat = status; // command word is write only, others read zero
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            ack_ff <= 1'b0;
            rdat_ff <= '0;
        end else begin
            ack_ff <= nxt_ack;
            rdat_ff <= nxt_rdat;
        end
    end

    assign o_wb_ack = ack_ff;
    assign o_wb_dat = rdat_ff;

    // ---------------------------------------------------------------
    // command decode
    // ---------------------------------------------------------------
    assign cmd.wr_stb = wr_cmd;
    assign cmd.wr_data = i_wb_dat[7:0];

    uart_cmd_decode u_decode (
        .i_clock(i_clock),
        .i_nrst(i_nrst),
        .cmd(cmd.decoder)
    );

    // action pulses come straight from the decoder flip-flops
    assign o_mode_ptr_reset = cmd.mode_ptr_reset; // R7
    assign o_rx_reset = cmd.rx_reset; // R8
    assign o_tx_reset = cmd.tx_reset; // R10
    assign o_err_clear = cmd.err_clear; // R12
    assign o_dbrk_clear = cmd.dbrk_clear; // R13

    // ---------------------------------------------------------------
    // autobaud control
    // ---------------------------------------------------------------
    logic ab_en_ff;
    logic nxt_ab_en;
    logic ab_done_ff;
    logic nxt_ab_done;
    logic ab_set;
    logic ab_clr;

    // enable follows bit 7; a fresh enable rearms the complete flag
    always_comb begin
        nxt_ab_en = ab_en_ff;
        if (wr_cmd) begin
            nxt_ab_en = i_wb_dat[CMD_AUTOBAUD_BIT]; // R2
        end
        ab_set = i_autobaud_loaded && ab_en_ff; // R4
        ab_clr = (wr_status && i_wb_dat[ST_AB_COMPLETE]) || (nxt_ab_en && !ab_en_ff); // R3
        nxt_ab_done = ab_set || (ab_done_ff && !ab_clr); // set wins over clear
    end

    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            ab_en_ff <= RST_AB_ENABLE;
            ab_done_ff <= RST_AB_COMPLETE;
        end else begin
            ab_en_ff <= nxt_ab_en;
            ab_done_ff <= nxt_ab_done;
        end
    end

    assign o_autobaud_enable = ab_en_ff;

    // ---------------------------------------------------------------
    // break sequencer
    // ---------------------------------------------------------------
    brk_state_e brk_ff;
    brk_state_e nxt_brk;
    logic hold_ff;
    logic nxt_hold;

    // break waits for the shifter; stop always wins
    always_comb begin
        nxt_brk = brk_ff;
        unique case (brk_ff)
            BRK_IDLE: begin
                if (cmd.brk_start && i_tx_enabled) begin
                    nxt_brk = i_tx_shift_busy ? BRK_WAIT : BRK_ON; // R14
                end
            end
            BRK_WAIT: begin
                if (cmd.brk_stop) begin
                    nxt_brk = BRK_IDLE; // R15
                end else if (!i_tx_shift_busy) begin
                    nxt_brk = BRK_ON; // R14
                end
            end
            BRK_ON: begin
                if (cmd.brk_stop) begin
                    nxt_brk = BRK_IDLE; // R15
                end
            end
            default: nxt_brk = BRK_IDLE;
        endcase
        nxt_hold = nxt_brk != BRK_IDLE; // R14
    end

    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            brk_ff <= BRK_IDLE;
            hold_ff <= 1'b0;
        end else begin
            brk_ff <= nxt_brk;
            hold_ff <= nxt_hold;
        end
    end

    assign o_tx_break = brk_ff[1]; // line held low while break is on
    assign o_tx_hold = hold_ff; // holding register waits, own flop so the pin is glitch free

    // status word
    always_comb begin
        status = '0;
        status[ST_AB_ENABLE] = ab_en_ff;
        status[ST_AB_COMPLETE] = ab_done_ff;
        status[ST_BRK_WAIT] = brk_ff == BRK_WAIT;
        status[ST_BRK_ON] = brk_ff == BRK_ON;
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_nrst);

    sequence s_start_busy;
        brk_ff == BRK_IDLE && cmd.brk_start && i_tx_enabled && i_tx_shift_busy;
    endsequence
    sequence s_shift_done;
        brk_ff == BRK_WAIT && !i_tx_shift_busy && !cmd.brk_stop;
    endsequence

    a_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack held longer than one cycle");
    a_autobaud_bit: assert property (wr_cmd
        |=> o_autobaud_enable == $past(i_wb_dat[CMD_AUTOBAUD_BIT])) // R2
        else $error("autobaud enable does not follow bit 7");
    a_ab_done_set: assert property (i_autobaud_loaded && ab_en_ff |=> ab_done_ff) // R4
        else $error("autobaud complete not set");
    a_ab_done_cause: assert property ($rose(ab_done_ff) |-> $past(i_autobaud_loaded && ab_en_ff)) // R4
        else $error("autobaud complete without a loaded rate");
    a_brk_waits_shift: assert property (s_start_busy |=> !o_tx_break && o_tx_hold) // R14
        else $error("break began while a character was shifting");
    a_brk_after_shift: assert property (s_shift_done |=> o_tx_break) // R14
        else $error("break did not begin after the character");
    a_brk_needs_tx: assert property (brk_ff == BRK_IDLE && cmd.brk_start && !i_tx_enabled
        |=> !o_tx_hold) // R14
        else $error("break accepted with transmitter disabled");
    a_brk_stop: assert property (cmd.brk_stop |=> !o_tx_break && !o_tx_hold) // R15
        else $error("break not ended by stop");
    a_cmd_to_break: assert property (wr_cmd
        && i_wb_dat[CMD_SEL_HI:CMD_SEL_LO] == SEL_BRK_START && brk_ff == BRK_IDLE
        && i_tx_enabled && !i_tx_shift_busy |=> ##1 o_tx_break) // R14
        else $error("start break not seen two cycles after the write");
endmodule : uart_command_decoder

// *** tb/tb.sv ***
// self-checking bench for the uart command register block
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
    $display("unexpected at %0t: got %0h want %0h", $time, (g), (e)); end end
module tb;
    import uart_cmd_pkg::*;
    logic i_clock = 1'b0;
    logic i_nrst = 1'b0;
    logic i_wb_cyc, i_wb_stb, i_wb_we, i_tx_enabled, i_tx_shift_busy, i_autobaud_loaded;
    logic [ADR_W-1:0] i_wb_adr;
    logic [SEL_W-1:0] i_wb_sel;
    logic [DAT_W-1:0] i_wb_dat, o_wb_dat, rdat;
    logic o_wb_ack, o_autobaud_enable, o_mode_ptr_reset, o_rx_reset, o_tx_reset;
    logic o_err_clear, o_dbrk_clear, o_tx_break, o_tx_hold;
    logic [4:0] pulses;
    int bad_count = 0;
    int tests_run = 0;
    int ab_en = 0;
    int ab_cpl = 0;
    int brk = 0;
    // ------------------------------------------------------------------
    // clock, design and grouped action pulses
    // ------------------------------------------------------------------
    always #5 i_clock = ~i_clock;
    assign pulses = {o_mode_ptr_reset, o_rx_reset, o_tx_reset, o_err_clear, o_dbrk_clear};
    uart_command_decoder uart_command_decoder_i (
        .i_clock(i_clock), .i_nrst(i_nrst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
        .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
        .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_tx_enabled(i_tx_enabled),
        .i_tx_shift_busy(i_tx_shift_busy), .i_autobaud_loaded(i_autobaud_loaded),
        .o_autobaud_enable(o_autobaud_enable), .o_mode_ptr_reset(o_mode_ptr_reset),
        .o_rx_reset(o_rx_reset), .o_tx_reset(o_tx_reset), .o_err_clear(o_err_clear),
        .o_dbrk_clear(o_dbrk_clear), .o_tx_break(o_tx_break), .o_tx_hold(o_tx_hold));
    // ------------------------------------------------------------------
    // reference model and bus tasks
    // ------------------------------------------------------------------
    // expected status word from the model state
    function automatic logic [DAT_W-1:0] st_exp();
        return DAT_W'({brk == 2, brk == 1, ab_cpl[0], ab_en[0]});
    endfunction : st_exp
    // one pulse line per selector 1..5, none otherwise
    function automatic logic [4:0] exp_pulse(input int s);
        return (s >= 1 && s <= 5) ? 5'(5'h10 >> (s - 1)) : 5'h0;
    endfunction : exp_pulse
    // prints the counts and the verdict, then ends the run
    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stop_test
    // classic single wishbone cycle, held until ack is sampled high
    task automatic bus(input logic we, input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] d,
            input logic [SEL_W-1:0] s);
        int n;
        n = 0;
        @(posedge i_clock);
        i_wb_cyc <= 1'b1;
        i_wb_stb <= 1'b1;
        i_wb_we <= we;
        i_wb_adr <= a;
        i_wb_dat <= d;
        i_wb_sel <= s;
        do begin
            @(posedge i_clock);
            n++;
        end while (o_wb_ack !== 1'b1 && n < 20);
        if (o_wb_ack !== 1'b1) begin
            bad_count++;
            stop_test();
        end
        rdat = o_wb_dat;
        i_wb_cyc <= 1'b0;
        i_wb_stb <= 1'b0;
        i_wb_we <= 1'b0;
    endtask : bus
    // command write with random unused upper bits, then model update
    task automatic wr_cmd(input logic [7:0] c);
        logic [DAT_W-1:0] d;
        d = $urandom();
        d[7:0] = c;
        bus(1'b1, OFS_COMMAND, d, 4'h1);
        if (c[7] && ab_en == 0) ab_cpl = 0;
        ab_en = c[7];
        if (c[6:4] == 3'h7) brk = 0;
        if (c[6:4] == 3'h6 && i_tx_enabled && brk == 0) brk = i_tx_shift_busy ? 1 : 2;
    endtask : wr_cmd
    task automatic rd_chk(input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] e);
        bus(1'b0, a, 32'h0, 4'hf);
        `CHK(rdat, e)
    endtask : rd_chk
    // one-cycle divider-loaded pulse from the rate detector
    task automatic load_pulse();
        @(posedge i_clock);
        i_autobaud_loaded <= 1'b1;
        @(posedge i_clock);
        i_autobaud_loaded <= 1'b0;
        if (ab_en != 0) ab_cpl = 1;
    endtask : load_pulse
    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        void'($urandom(50106));
        {i_wb_cyc, i_wb_stb, i_wb_we, i_tx_enabled, i_tx_shift_busy, i_autobaud_loaded} = 6'h0;
        i_wb_adr = '0;
        i_wb_sel = '0;
        i_wb_dat = '0;
        repeat (12) @(posedge i_clock);
        i_nrst <= 1'b1;
        @(posedge i_clock);
        `CHK({o_wb_ack, o_autobaud_enable, pulses, o_tx_break, o_tx_hold}, 9'h0)
        rd_chk(OFS_STATUS, st_exp());
        // every selector, random autobaud bit, transmitter off
        for (int s = 0; s < 8; s++) begin
            wr_cmd({1'($urandom_range(1, 0)), 3'(s), 4'h0});
            @(posedge i_clock);
            `CHK(pulses, exp_pulse(s))
            `CHK(o_autobaud_enable, ab_en[0])
            @(posedge i_clock);
            `CHK({pulses, o_tx_break, o_tx_hold}, 7'h0)
        end
        // ignored writes: low byte disabled, unmapped place, write-only read
        bus(1'b1, OFS_COMMAND, {24'h0, ~ab_en[0], 7'h10}, 4'he);
        @(posedge i_clock);
        `CHK({pulses, o_autobaud_enable}, {5'h0, ab_en[0]})
        bus(1'b1, 4'h8, 32'h10, 4'h1);
        @(posedge i_clock);
        `CHK(pulses, 5'h0)
        rd_chk(4'h8, 32'h0);
        rd_chk(OFS_COMMAND, 32'h0);
        // autobaud complete: set only while enabled, cleared by w1c and re-enable
        wr_cmd(8'h00);
        load_pulse();
        rd_chk(OFS_STATUS, st_exp());
        // divider bytes are taken as zeroed by software before enabling
        wr_cmd(8'h80);
        load_pulse();
        rd_chk(OFS_STATUS, st_exp());
        bus(1'b1, OFS_STATUS, 32'h2, 4'h1);
        ab_cpl = 0;
        rd_chk(OFS_STATUS, st_exp());
        load_pulse();
        wr_cmd(8'h00);
        wr_cmd(8'h80);
        rd_chk(OFS_STATUS, st_exp());
        // break with idle shifter, then behind a shifting character
        i_tx_enabled <= 1'b1;
        wr_cmd(8'h60);
        repeat (2) @(posedge i_clock);
        `CHK({o_tx_break, o_tx_hold}, 2'b11)
        rd_chk(OFS_STATUS, st_exp());
        wr_cmd(8'h70);
        repeat (2) @(posedge i_clock);
        `CHK({o_tx_break, o_tx_hold}, 2'b00)
        i_tx_shift_busy <= 1'b1;
        wr_cmd(8'h60);
        repeat (4) @(posedge i_clock);
        `CHK({o_tx_break, o_tx_hold}, 2'b01)
        rd_chk(OFS_STATUS, st_exp());
        i_tx_shift_busy <= 1'b0;
        brk = 2;
        repeat (3) @(posedge i_clock);
        `CHK({o_tx_break, o_tx_hold}, 2'b11)
        wr_cmd(8'h70);
        repeat (2) @(posedge i_clock);
        `CHK({o_tx_break, o_tx_hold}, 2'b00)
        stop_test();
    end
endmodule : tb
